// *** design/nca_nvm_access.sv ***
// NVM access block: AHB-Lite register set steering the Flash, EEPROM and configuration arrays
// Function
// RULE1 - Configuration select set routes reads and writes to configuration region.
// RULE2 - Disallowed configuration read clears both data registers to zero.
// RULE3 - User IDs 0-3 read/write; device ID 6 and config words 7-8 read-only.
// RULE4 - Low data register is eight bits: EEPROM byte or program word bits 7-0.
// RULE5 - High data register holds word bits 13-8; bits 7-6 read zero.
// RULE6 - Low address register is eight bits, resets to zero.
// RULE7 - High address holds address bits 14-8; bit 7 reads one.
// RULE8 - Control bit 7 selects Flash when set, EEPROM when clear; resets zero.
// RULE9 - Control bit 6 selects configuration space when set.
// RULE10 - Latch-only set on Flash or config: program start only loads latches.
// RULE11 - Latch-only clear: load latches then write whole latch contents.
// RULE12 - EEPROM target ignores latch-only; every start writes the location.
// RULE13 - EEPROM target ignores erase select; start erases then writes.
// RULE14 - Erase select makes next start erase; hardware clears it afterward.
// RULE15 - Error flag sets on any program start attempt; clears on normal completion.
// RULE16 - Program enable clear blocks every program and erase cycle.
// RULE17 - Program start is set-only by software, cleared by hardware when done.
// RULE18 - Read start is set-only; one-cycle read, then hardware clears it.
// RULE19 - Unlock register is write-only with no readable storage.
// RULE20 - Software should read back and compare every write.
// RULE21 - Software writes 55h then AAh to unlock before program start.
// RULE22 - Two setup cycles after start, then core stalls during the timed cycle.
// RULE23 - Program attempt on read-only configuration address leaves contents unchanged.
`default_nettype none
module nca_nvm_access
    import nca_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
)(
    input  wire logic          sys_clk_i,
    input  wire logic          reset_i,
    input  wire logic          hsel_i,
    input  wire logic [31:0]   haddr_i,
    input  wire logic [1:0]    htrans_i,
    input  wire logic          hwrite_i,
    input  wire logic [2:0]    hsize_i,
    input  wire logic [31:0]   hwdata_i,
    input  wire logic          hready_i,
    output logic               hreadyout_o,
    output logic               hresp_o,
    output logic [31:0]        hrdata_o,
    input  wire logic [13:0]   arr_rdata_i,
    output nca_arr_req_t       arr_req_o,
    output logic               core_ignore_o,
    output logic               core_stall_o
);
    localparam logic [CNT_W-1:0] RUN_LOAD   = CNT_W'(PROG_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYCLES - 1);

    nca_state_t st_reg;
    nca_state_t st_next;
    logic       acc;
    logic       acc_rd;
    logic       is_eeprom;
    logic       cfg_rd_ok;
    logic       cfg_wr_ok;

    assign acc = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    assign acc_rd = acc && !hwrite_i;
    assign is_eeprom = !st_reg.ctl.fsel && !st_reg.ctl.csel;
    // Config space is addressed through the low byte with the high byte clear
    assign cfg_rd_ok = st_reg.adr_hi == ADR_HI_RST
                       && (st_reg.adr_lo <= CFG_UID_MAX
                       || (st_reg.adr_lo >= CFG_RO_MIN
                       && st_reg.adr_lo <= CFG_RO_MAX));                 // [RULE3]
    assign cfg_wr_ok = st_reg.adr_hi == ADR_HI_RST
                       && st_reg.adr_lo <= CFG_UID_MAX;                  // [RULE3]

    function automatic logic [31:0] read_mux(input nca_state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = '0;
        case (a)
            OFS_DATA_LO: d[7:0] = s.dat_lo;                              // [RULE4]
            OFS_DATA_HI: d[5:0] = s.dat_hi;                              // [RULE5]
            OFS_ADR_LO:  d[7:0] = s.adr_lo;                              // [RULE6]
            OFS_ADR_HI:  d[7:0] = {1'b1, s.adr_hi};                      // [RULE7]
            OFS_CTRL:    d[7:0] = s.ctl;
            default:     d = '0;                                         // [RULE19]
        endcase
        return d;
    endfunction

    always_comb
    begin
        st_next = st_reg;
        // Bus write data phase
        if (st_reg.dp_wr)
        begin
            // Any write other than the second key breaks the unlock pair
            st_next.key_half = 1'b0;
            st_next.unlocked = 1'b0;
            case (st_reg.dp_addr)
                OFS_DATA_LO: st_next.dat_lo = hwdata_i[7:0];
                OFS_DATA_HI: st_next.dat_hi = hwdata_i[5:0];
                OFS_ADR_LO:  st_next.adr_lo = hwdata_i[7:0];
                OFS_ADR_HI:  st_next.adr_hi = hwdata_i[6:0];
                OFS_CTRL:
                begin
                    st_next.ctl.fsel = hwdata_i[CB_FSEL];                // [RULE8]
                    st_next.ctl.csel = hwdata_i[CB_CSEL];                // [RULE9]
                    st_next.ctl.latch = hwdata_i[CB_LATCH];
                    st_next.ctl.pgen = hwdata_i[CB_PGEN];
                    // Freeze erase select while an operation uses it
                    if (st_reg.fsm == ST_IDLE)
                        st_next.ctl.free = hwdata_i[CB_FREE];
                    st_next.ctl.err = hwdata_i[CB_ERR];
                    if (hwdata_i[CB_RD] && st_reg.fsm == ST_IDLE)
                        st_next.ctl.rd = 1'b1;                           // [RULE18]
                    if (hwdata_i[CB_WR] && !st_reg.ctl.wr)
                    begin
                        st_next.ctl.err = 1'b1;                          // [RULE15]
                        if (st_reg.unlocked && st_reg.ctl.pgen && st_reg.fsm == ST_IDLE)
                        begin
                            st_next.ctl.wr = 1'b1;                       // [RULE17] [RULE21]
                            st_next.fsm = ST_SETUP;                      // [RULE22]
                            st_next.cnt = SETUP_LOAD;
                        end
                    end
                end
                OFS_KEY:
                begin
                    if (hwdata_i[7:0] == KEY_FIRST)
                        st_next.key_half = 1'b1;
                    else if (hwdata_i[7:0] == KEY_SECOND && st_reg.key_half)
                        st_next.unlocked = 1'b1;                         // [RULE21]
                end
                default: ;
            endcase
        end
        // One-cycle array read, the array answers in the same cycle
        if (st_reg.ctl.rd)
        begin
            st_next.ctl.rd = 1'b0;                                       // [RULE18]
            if (st_reg.ctl.csel && !cfg_rd_ok)
            begin
                st_next.dat_lo = '0;                                     // [RULE2]
                st_next.dat_hi = '0;
            end
            else
            begin
                st_next.dat_lo = arr_rdata_i[7:0];                       // [RULE4]
                st_next.dat_hi = arr_rdata_i[13:8];                      // [RULE5]
            end
        end
        // Program and erase sequencer
        case (st_reg.fsm)
            ST_IDLE: st_next.op = OP_NONE;
            ST_SETUP:
            begin
                st_next.cnt = st_reg.cnt - CNT_W'(1);
                if (st_reg.cnt == '0)
                begin
                    st_next.cnt = RUN_LOAD;
                    if (!st_reg.ctl.pgen || (st_reg.ctl.csel && !cfg_wr_ok))
                    begin
                        // Blocked or read-only target: abort, flag stays set
                        st_next.fsm = ST_IDLE;                           // [RULE16] [RULE23]
                        st_next.ctl.wr = 1'b0;
                    end
                    else if (is_eeprom)
                    begin
                        st_next.fsm = ST_RUN;                            // [RULE12]
                        st_next.op = OP_ERASE;                           // [RULE13]
                    end
                    else if (st_reg.ctl.free)
                    begin
                        st_next.fsm = ST_RUN;                            // [RULE14]
                        st_next.op = OP_ERASE;
                    end
                    else
                    begin
                        st_next.fsm = ST_LATCH;
                        st_next.op = OP_LATCH;
                    end
                end
            end
            ST_LATCH:
            begin
                if (st_reg.ctl.latch)
                begin
                    st_next.fsm = ST_IDLE;                               // [RULE10]
                    st_next.op = OP_NONE;
                    st_next.ctl.wr = 1'b0;
                    st_next.ctl.err = 1'b0;
                end
                else
                begin
                    st_next.fsm = ST_RUN;                                // [RULE11]
                    st_next.op = OP_WRITE;
                end
            end
            ST_RUN:
            begin
                st_next.cnt = st_reg.cnt - CNT_W'(1);
                if (st_reg.cnt == '0)
                begin
                    if (st_reg.op == OP_ERASE && is_eeprom)
                    begin
                        st_next.op = OP_WRITE;                           // [RULE13]
                        st_next.cnt = RUN_LOAD;
                    end
                    else
                    begin
                        if (st_reg.op == OP_ERASE)
                            st_next.ctl.free = 1'b0;                     // [RULE14]
                        st_next.fsm = ST_IDLE;
                        st_next.op = OP_NONE;
                        st_next.ctl.wr = 1'b0;                           // [RULE17]
                        st_next.ctl.err = 1'b0;                          // [RULE15]
                    end
                end
            end
            default: st_next.fsm = ST_IDLE;
        endcase
        // Address phase; read data comes from the updated copy so a write
        // in the preceding data phase is seen without a wait state
        st_next.dp_wr = acc && hwrite_i;
        if (acc)
            st_next.dp_addr = haddr_i[7:0];
        if (acc_rd)
            st_next.hrdata = read_mux(st_next, haddr_i[7:0]);
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_reg <= '{
                ctl: '0, dat_lo: '0, dat_hi: '0,
                adr_lo: ADR_LO_RST, adr_hi: ADR_HI_RST,
                key_half: 1'b0, unlocked: 1'b0,
                fsm: ST_IDLE, op: OP_NONE, cnt: '0,
                dp_wr: 1'b0, dp_addr: '0, hrdata: '0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Zero-wait slave: every access completes with OKAY in its first data cycle
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = st_reg.hrdata;
    assign arr_req_o.rd = st_reg.ctl.rd;
    assign arr_req_o.op = st_reg.op;
    assign arr_req_o.space = st_reg.ctl.csel ? SP_CFG :
                             (st_reg.ctl.fsel ? SP_FLASH : SP_EEPROM);   // [RULE1] [RULE8]
    assign arr_req_o.addr = {st_reg.adr_hi, st_reg.adr_lo};
    assign arr_req_o.wdata = {st_reg.dat_hi, st_reg.dat_lo};
    assign core_ignore_o = st_reg.fsm == ST_SETUP;                       // [RULE22]
    // Latch loads do not stall the core, only timed array cycles do
    assign core_stall_o = st_reg.fsm == ST_RUN;                          // [RULE22]

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    property p_cfg_route;
        st_reg.ctl.csel |-> arr_req_o.space == SP_CFG;
    endproperty
    a_cfg_route: assert property (p_cfg_route) else $error("config select not routed"); // [RULE1]

    property p_bad_cfg_read;
        st_reg.ctl.rd && st_reg.ctl.csel && !cfg_rd_ok
            |=> st_reg.dat_lo == 8'h00 && st_reg.dat_hi == 6'h00;
    endproperty
    a_bad_cfg_read: assert property (p_bad_cfg_read) else $error("bad read kept data"); // [RULE2]

    property p_cfg_ro;
        st_reg.fsm inside {ST_LATCH, ST_RUN} && st_reg.ctl.csel |-> cfg_wr_ok;
    endproperty
    a_cfg_ro: assert property (p_cfg_ro) else $error("read-only config written"); // [RULE23]

    property p_adr_hi_msb;
        acc_rd && haddr_i[7:0] == OFS_ADR_HI |=> hrdata_o[7:0] == {1'b1, st_reg.adr_hi};
    endproperty
    a_adr_hi_msb: assert property (p_adr_hi_msb) else $error("address high bit 7 not one"); // [RULE7]

    property p_dat_hi_top;
        acc_rd && haddr_i[7:0] == OFS_DATA_HI |=> hrdata_o[7:6] == 2'b00;
    endproperty
    a_dat_hi_top: assert property (p_dat_hi_top) else $error("data high bits 7-6 set"); // [RULE5]

    property p_latch_only;
        st_reg.op == OP_LATCH && st_reg.ctl.latch |=> st_reg.op == OP_NONE && !st_reg.ctl.wr;
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("latch-only started write"); // [RULE10]

    property p_latch_write;
        st_reg.op == OP_LATCH && !st_reg.ctl.latch |=> st_reg.op == OP_WRITE && core_stall_o;
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch not followed by write"); // [RULE11]

    property p_ee_erase_write;
        st_reg.fsm == ST_RUN && st_reg.op == OP_ERASE && is_eeprom && st_reg.cnt == '0
            |=> st_reg.op == OP_WRITE && st_reg.ctl.wr;
    endproperty
    a_ee_erase_write: assert property (p_ee_erase_write) else $error("EEPROM erase without write"); // [RULE13]

    property p_start_guard;
        $rose(st_reg.ctl.wr) |-> $past(st_reg.unlocked) && $past(st_reg.ctl.pgen) && st_reg.ctl.err;
    endproperty
    a_start_guard: assert property (p_start_guard) else $error("start without unlock or flag"); // [RULE15]

    sequence s_setup_two;
        core_ignore_o ##1 core_ignore_o ##1 !core_ignore_o;
    endsequence
    property p_setup;
        $rose(st_reg.ctl.wr) |-> s_setup_two;
    endproperty
    a_setup: assert property (p_setup) else $error("setup not two cycles"); // [RULE22]

    property p_rd_pulse;
        st_reg.ctl.rd |=> !st_reg.ctl.rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read start not cleared"); // [RULE18]

    property p_no_enable;
        st_reg.fsm == ST_SETUP && !st_reg.ctl.pgen |=> st_reg.op inside {OP_NONE, OP_LATCH} ##0 !core_stall_o;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("cycle ran with enable clear"); // [RULE16]

    // The key register has no storage behind it
    property p_key_read;
        acc_rd && haddr_i[7:0] == OFS_KEY |=> hrdata_o == 32'h0;
    endproperty
    a_key_read: assert property (p_key_read) else $error("key register readable"); // [RULE19]

    property p_adr_lo_read;
        acc_rd && haddr_i[7:0] == OFS_ADR_LO |=> hrdata_o[31:8] == 24'h0;
    endproperty
    a_adr_lo_read: assert property (p_adr_lo_read) else $error("address low too wide"); // [RULE6]

    property p_space_flash;
        !st_reg.ctl.csel && st_reg.ctl.fsel |-> arr_req_o.space == SP_FLASH;
    endproperty
    a_space_flash: assert property (p_space_flash) else $error("flash not routed"); // [RULE8]

    // The array word lands in both data registers at the end of the read pulse
    property p_rd_capture;
        st_reg.ctl.rd && !st_reg.ctl.csel
            |=> {st_reg.dat_hi, st_reg.dat_lo} == $past(arr_rdata_i);
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("read word lost"); // [RULE4] [RULE5]

    // Software cannot drop the start bit; it falls only as the sequencer idles
    property p_wr_hw_clear;
        $fell(st_reg.ctl.wr) |-> $past(st_reg.fsm) != ST_IDLE && st_reg.fsm == ST_IDLE;
    endproperty
    a_wr_hw_clear: assert property (p_wr_hw_clear) else $error("start bit cleared early"); // [RULE17]

    property p_free_clear;
        st_reg.fsm == ST_RUN && st_reg.op == OP_ERASE && !is_eeprom && st_reg.cnt == '0
            |=> !st_reg.ctl.free;
    endproperty
    a_free_clear: assert property (p_free_clear) else $error("erase select kept"); // [RULE14]

    property p_err_clear;
        st_reg.fsm == ST_RUN && st_reg.op == OP_WRITE && st_reg.cnt == '0
            |=> !st_reg.ctl.err && !st_reg.ctl.wr;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("flag kept after write"); // [RULE15]

    property p_stall_op;
        core_stall_o |-> st_reg.op inside {OP_ERASE, OP_WRITE};
    endproperty
    a_stall_op: assert property (p_stall_op) else $error("stall without array cycle"); // [RULE22]

    // A start attempt without the key pair only raises the flag
    sequence s_start_try;
        st_reg.dp_wr && st_reg.dp_addr == OFS_CTRL && hwdata_i[CB_WR] && !st_reg.ctl.wr;
    endsequence
    property p_locked_start;
        s_start_try ##0 (!st_reg.unlocked && st_reg.fsm == ST_IDLE)
            |=> st_reg.fsm == ST_IDLE && st_reg.ctl.err;
    endproperty
    a_locked_start: assert property (p_locked_start) else $error("locked start ran"); // [RULE15]
endmodule
`default_nettype wire

// *** design/nca_pkg.sv ***
// Package: register map, field positions, timing and carrier types of the NVM access block
`default_nettype none
package nca_pkg;
    localparam logic [7:0] OFS_DATA_LO = 8'h00;
    localparam logic [7:0] OFS_DATA_HI = 8'h04;
    localparam logic [7:0] OFS_ADR_LO  = 8'h08;
    localparam logic [7:0] OFS_ADR_HI  = 8'h0c;
    localparam logic [7:0] OFS_CTRL    = 8'h10;
    localparam logic [7:0] OFS_KEY     = 8'h14;
    localparam int CB_FSEL = 7;
    localparam int CB_CSEL = 6;
    localparam int CB_LATCH = 5;
    localparam int CB_FREE = 4;
    localparam int CB_ERR  = 3;
    localparam int CB_PGEN = 2;
    localparam int CB_WR   = 1;
    localparam int CB_RD   = 0;
    localparam logic [7:0] KEY_FIRST   = 8'h55;
    localparam logic [7:0] KEY_SECOND  = 8'haa;
    localparam logic [7:0] CFG_UID_MAX = 8'h03;
    localparam logic [7:0] CFG_RO_MIN  = 8'h06;
    localparam logic [7:0] CFG_RO_MAX  = 8'h08;
    localparam logic [6:0] ADR_HI_RST  = 7'h00;
    localparam logic [7:0] ADR_LO_RST  = 8'h00;
    localparam int PROG_TIME_NS  = 2000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES  = 2;
    localparam int CNT_W         = 20;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    typedef enum logic [1:0] {SP_EEPROM, SP_FLASH, SP_CFG} nca_space_t;
    typedef enum logic [1:0] {OP_NONE, OP_LATCH, OP_ERASE, OP_WRITE} nca_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LATCH, ST_RUN} nca_fsm_t;
    typedef struct packed {
        logic fsel;
        logic csel;
        logic latch;
        logic free;
        logic err;
        logic pgen;
        logic wr;
        logic rd;
    } nca_ctrl_t;
    typedef struct packed {
        logic       rd;
        nca_op_t    op;
        nca_space_t space;
        logic [14:0] addr;
        logic [13:0] wdata;
    } nca_arr_req_t;
    typedef struct packed {
        nca_ctrl_t  ctl;
        logic [7:0] dat_lo;
        logic [5:0] dat_hi;
        logic [7:0] adr_lo;
        logic [6:0] adr_hi;
        logic       key_half;
        logic       unlocked;
        nca_fsm_t   fsm;
        nca_op_t    op;
        logic [CNT_W-1:0] cnt;
        logic       dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
    } nca_state_t;
endpackage
`default_nettype wire

// *** tb/nca_arr_model.sv ***
// Behavioural model of the Flash, EEPROM and configuration arrays with their write latches
`default_nettype none
module nca_arr_model
    import nca_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire nca_arr_req_t req_i,
    output logic [13:0]       rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] mem   [logic [16:0]];
    logic [13:0] latch [logic [16:0]];
    nca_op_t     op_prev = OP_NONE;
    logic [13:0] noise   = 14'h2a55;
    logic [16:0] key;
    assign key = {req_i.space, req_i.addr};
    // Outside a read the word toggles every cycle so a late capture cannot look right
    always_comb rdata_o = !req_i.rd ? noise : (mem.exists(key) ? mem[key] : 14'h3fff);
    always @(posedge sys_clk_i)
    begin
        noise <= ~noise;
        op_prev <= req_i.op;
        if (req_i.op == OP_LATCH)
            latch[key] = req_i.wdata;
        if (req_i.op == OP_ERASE && op_prev != OP_ERASE)
            mem[key] = 14'h3fff;
        if (req_i.op == OP_WRITE && op_prev != OP_WRITE)
        begin
            if (req_i.space == SP_EEPROM)
                mem[key] = req_i.wdata;
            else
            begin
                foreach (latch[k])
                    mem[k] = latch[k];
                latch.delete();
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench: AHB-Lite master, array model and queued read-data checks
`default_nettype none
module testbench
    import nca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 8;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'b00;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    logic [13:0]  arr_rdata;
    nca_arr_req_t arr_req;
    logic         core_ignore;
    logic         core_stall;
    logic [63:0]  exp_q [$];
    logic         rd_dp = 1'b0;
    logic [31:0]  lfsr = 32'h5b7e;
    int           err_count = 0;
    int           check_count = 0;
    int           cyc = 0;
    logic [13:0]  va;
    logic [13:0]  vb;
    initial forever #2.5 clk = ~clk;
    nca_nvm_access #(.PROG_CYCLES(P)) dut (
        .sys_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .hrdata_o(hrdata), .arr_rdata_i(arr_rdata), .arr_req_o(arr_req),
        .core_ignore_o(core_ignore), .core_stall_o(core_stall));
    nca_arr_model arrays (.sys_clk_i(clk), .req_i(arr_req), .rdata_o(arr_rdata));
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input int got, input int exp, input string what);
        check_count++;
        if (got != exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    // One single transfer; a read only notes its expectation, the monitor compares
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [7:0] e, input logic [7:0] m);
        if (!w)
            exp_q.push_back({24'h0, e, 24'hffffff, m});
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 8'h00, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(1'b0, a, 32'h0, e, m);
    endtask
    // Program start with optional unlock; counts setup and stall cycles that follow
    task automatic start(input logic [7:0] c, input logic unl, input int ign, input int stl);
        int ni;
        int ns;
        ni = 0;
        ns = 0;
        if (unl)
        begin
            wr(OFS_KEY, {24'h0, KEY_FIRST});
            wr(OFS_KEY, {24'h0, KEY_SECOND});
        end
        wr(OFS_CTRL, {24'h0, c});
        repeat (2 * P + 12)
        begin
            @(posedge clk);
            ni += (core_ignore === 1'b1);
            ns += (core_stall === 1'b1);
        end
        check(ni, ign, "setup cycles");
        check(ns, stl, "stall cycles");
    endtask
    task automatic readback(input logic [7:0] c, input logic [13:0] v);
        wr(OFS_DATA_LO, 32'h5a);
        wr(OFS_CTRL, {24'h0, c});
        repeat (2) @(posedge clk);
        rd(OFS_DATA_LO, v[7:0], 8'hff);
        rd(OFS_DATA_HI, {2'b00, v[13:8]}, 8'hff);
        rd(OFS_CTRL, 8'h00, 8'h01);
    endtask
    task automatic endtest(input string name);
        $display("test %s done", name);
    endtask
    always @(posedge clk)
    begin
        logic [63:0] n;
        if (rd_dp)
        begin
            n = (exp_q.size() > 0) ? exp_q.pop_front() : 64'hffffffff_00000000;
            check_count++;
            if ((hrdata & n[31:0]) !== (n[63:32] & n[31:0]) || hresp !== 1'b0)
            begin
                err_count++;
                $display("wrong value at %0t: read %h expected %h", $time, hrdata, n[63:32]);
            end
        end
        rd_dp <= !rst && hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout === 1'b1;
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_CTRL, 8'h00, 8'hff);
        rd(OFS_ADR_LO, ADR_LO_RST, 8'hff);
        rd(OFS_ADR_HI, {1'b1, ADR_HI_RST}, 8'hff);
        rd(OFS_KEY, 8'h00, 8'hff);
        rd(8'h18, 8'h00, 8'hff);
        for (int i = 0; i < 4; i++)
        begin
            lfsr = rnd(lfsr);
            wr(OFS_DATA_LO + 8'(4 * i), lfsr);
            rd(OFS_DATA_LO + 8'(4 * i), lfsr[7:0] & (i == 1 ? 8'h3f : 8'hff)
               | (i == 3 ? 8'h80 : 8'h00), 8'hff);
        end
        wr(OFS_ADR_HI, 32'h0);
        endtest("registers");
        lfsr = rnd(lfsr);
        va = lfsr[13:0];
        wr(OFS_ADR_LO, {24'h0, lfsr[23:16]});
        wr(OFS_DATA_HI, 32'h0);
        wr(OFS_DATA_LO, {24'h0, va[7:0]});
        wr(OFS_CTRL, 32'h34);
        start(8'h36, 1'b1, 2, 2 * P);
        rd(OFS_CTRL, 8'h00, 8'h0a);
        readback(8'h05, {6'h00, va[7:0]});
        endtest("eeprom");
        start(8'h06, 1'b0, 0, 0);
        rd(OFS_CTRL, 8'h08, 8'h0a);
        wr(OFS_CTRL, 32'h00);
        start(8'h02, 1'b1, 0, 0);
        rd(OFS_CTRL, 8'h08, 8'h0e);
        endtest("refusals");
        lfsr = rnd(lfsr);
        va = lfsr[13:0];
        vb = lfsr[29:16];
        wr(OFS_ADR_LO, 32'h10);
        wr(OFS_DATA_LO, {24'h0, va[7:0]});
        wr(OFS_DATA_HI, {26'h0, va[13:8]});
        wr(OFS_CTRL, 32'ha4);
        start(8'ha6, 1'b1, 2, 0);
        rd(OFS_CTRL, 8'h20, 8'h2a);
        wr(OFS_ADR_LO, 32'h11);
        wr(OFS_DATA_LO, {24'h0, vb[7:0]});
        wr(OFS_DATA_HI, {26'h0, vb[13:8]});
        wr(OFS_CTRL, 32'h84);
        start(8'h86, 1'b1, 2, P);
        wr(OFS_ADR_LO, 32'h10);
        readback(8'h81, va);
        wr(OFS_ADR_LO, 32'h11);
        readback(8'h81, vb);
        wr(OFS_CTRL, 32'h94);
        start(8'h96, 1'b1, 2, P);
        rd(OFS_CTRL, 8'h00, 8'h1a);
        readback(8'h81, 14'h3fff);
        endtest("flash");
        lfsr = rnd(lfsr);
        va = lfsr[13:0];
        wr(OFS_ADR_LO, 32'h02);
        wr(OFS_DATA_LO, {24'h0, va[7:0]});
        wr(OFS_DATA_HI, {26'h0, va[13:8]});
        wr(OFS_CTRL, 32'h44);
        start(8'h46, 1'b1, 2, P);
        readback(8'h41, va);
        wr(OFS_ADR_LO, 32'h06);
        wr(OFS_DATA_LO, 32'h00);
        wr(OFS_CTRL, 32'h44);
        start(8'h46, 1'b1, 2, 0);
        rd(OFS_CTRL, 8'h08, 8'h0a);
        readback(8'h41, 14'h3fff);
        wr(OFS_ADR_LO, 32'h05);
        readback(8'h41, 14'h0000);
        wr(OFS_ADR_LO, 32'h09);
        readback(8'h41, 14'h0000);
        endtest("config");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
